// ---- core/ccr_chopper_ctl.sv ----
// Purpose: Voltage-mode chopper control: mode, amplitude, standstill
// Assumes: Comparators are asynchronous; step inputs share core_clk_i
// Notes:   Velocity term uses a 16-step serial divider
//
// Function
// - Voltage mode off while step interval is below velocity threshold
// - Keep regulation state in current mode, resume from it later
// - Current range sets overcurrent threshold in three steps
// - Open-load flag per coil when target not reached recently
// - Total amplitude is 10-bit, saturating at 1023
// - Standstill option applied after power-down and hold ramp delays
// - Option codes: normal, standstill_option, low-side short, high-side short
// - Regulation frozen while target current is zero
// - Force-current bit forbids voltage mode
// - Slow-decay sense enable widens current measurement window
// - Optional regulation stop at standstill with reduced current
// - Switch limit gives upper nibble of amplitude cap on re-entry
// - Auto enable selects regulated or velocity-based amplitude
// - Auto-gradient selects tuned or programmed gradient
// - Rate code sets chopper period 1024, 683, 512 or 410 clocks
// - Gain 1..15 gives 0.5 to 7.5 correction steps per fullstep
// - Offset is velocity offset and tuning start; zero drops current term
// - Correction readout -255..255, frozen in current mode
// - Tuned offset and gradient readable as 8-bit values
// - Off time zero turns all driver transistors off
// - Blank time 16, 24, 36 or 54 clocks
// - Velocity amplitude is offset plus gradient*256/step interval
`timescale 1ns/1ns
module ccr_chopper_ctl
    import ccr_pkg::*;
(
    // Clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             rst_n_i,
    // Motion state
    input  wire logic [THR_W-1:0] step_interval_i,
    input  wire logic             standstill_i,
    input  wire logic             fullstep_i,
    input  wire logic [4:0]       actual_current_i,
    // Configuration
    input  wire logic [THR_W-1:0] voltage_mode_velocity_threshold_i,
    input  wire logic             force_current_chopper_i,
    input  wire logic             slow_decay_sense_enable_i,
    input  wire logic             standstill_reg_disable_i,
    input  wire logic             auto_amplitude_enable_i,
    input  wire logic             auto_gradient_enable_i,
    input  wire logic [3:0]       switch_amplitude_limit_i,
    input  wire logic [1:0]       pwm_rate_select_i,
    input  wire logic [3:0]       regulator_gain_i,
    input  wire logic [7:0]       amplitude_offset_i,
    input  wire logic [7:0]       amplitude_gradient_i,
    input  wire logic [1:0]       standstill_option_i,
    input  wire logic [4:0]       hold_current_i,
    input  wire logic [4:0]       run_current_i,
    input  wire logic [7:0]       power_down_delay_i,
    input  wire logic [3:0]       hold_ramp_delay_i,
    input  wire logic [1:0]       current_range_i,
    input  wire logic [3:0]       off_time_setting_i,
    input  wire logic [1:0]       blank_time_select_i,
    // Current comparators (asynchronous)
    input  wire logic             cmp_a_i,
    input  wire logic             cmp_b_i,
    // Driver control
    output logic                  driver_enable_o,
    output logic                  voltage_mode_o,
    output logic                  pwm_on_o,
    output logic                  blank_o,
    output logic                  period_o,
    output logic [1:0]            coil_mode_o,
    output logic [1:0]            ocp_threshold_o,
    // Status
    output logic                  open_load_coil_a_o,
    output logic                  open_load_coil_b_o,
    output logic [AMP_W-1:0]      total_pwm_amplitude_o,
    output logic signed [8:0]     amplitude_correction_o,
    output logic [7:0]            tuned_offset_o,
    output logic [7:0]            tuned_gradient_o
);
    // ************************************
    // Comparator synchronisers
    // ************************************
    logic [1:0] cmp_s1;
    logic [1:0] cmp_s2;
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmp_s1 <= '0;
            cmp_s2 <= '0;
        end else begin
            cmp_s1 <= {cmp_b_i, cmp_a_i};
            cmp_s2 <= cmp_s1;
        end
    end

    // ************************************
    // Mode selection
    // ************************************
    logic vm_allowed;
    logic vm_now;
    logic vm_prev;
    logic reentry;
    assign driver_enable_o = (off_time_setting_i != 4'h0);
    assign vm_allowed = !force_current_chopper_i;
    assign vm_now = vm_allowed && driver_enable_o
        && (step_interval_i >= voltage_mode_velocity_threshold_i);
    assign voltage_mode_o = vm_now;
    assign reentry = vm_now && !vm_prev;
    assign ocp_threshold_o = (current_range_i > OCP_MAX) ? OCP_MAX
                                                         : current_range_i;

    // ************************************
    // Chopper period counter
    // ************************************
    logic [10:0] per_n;
    logic [10:0] per_cnt;
    logic [10:0] per_half;
    assign per_n = (pwm_rate_select_i == 2'h0) ? PER_N0 :
                   (pwm_rate_select_i == 2'h1) ? PER_N1 :
                   (pwm_rate_select_i == 2'h2) ? PER_N2 : PER_N3;
    assign per_half = per_n >> 1;
    // Two period pulses per output cycle: pulse rate 2 / N, f_pwm = 1 / N
    assign period_o = (per_cnt == 11'h000) || (per_cnt == per_half);
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            per_cnt <= '0;
            vm_prev <= 1'b0;
        end else begin
            per_cnt <= (per_cnt >= per_n - 11'h001) ? 11'h000 : per_cnt + 11'h001;
            vm_prev <= vm_now;
        end
    end

    // ************************************
    // Duty and blanking
    // ************************************
    logic [20:0] duty_prod;
    logic [10:0] duty;
    logic        next_pwm_on;
    logic [5:0]  blank_len;
    logic [5:0]  blank_cnt;
    assign duty_prod = total_pwm_amplitude_o * per_n;
    assign duty = duty_prod[20:10];
    assign next_pwm_on = vm_now && (per_cnt < duty);
    assign blank_len = (blank_time_select_i == 2'h0) ? BLANK_0 :
                       (blank_time_select_i == 2'h1) ? BLANK_1 :
                       (blank_time_select_i == 2'h2) ? BLANK_2 : BLANK_3;
    assign blank_o = (blank_cnt != 6'h00);
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pwm_on_o  <= 1'b0;
            blank_cnt <= '0;
        end else begin
            pwm_on_o <= next_pwm_on;
            if (next_pwm_on != pwm_on_o) blank_cnt <= blank_len;
            else if (blank_o) blank_cnt <= blank_cnt - 6'h01;
        end
    end

    // ************************************
    // Current measurement window
    // ************************************
    logic       meas_win;
    logic [1:0] reached;
    assign meas_win = vm_now && !blank_o
        && (pwm_on_o || slow_decay_sense_enable_i);
    // Latches whether each coil reached target since the last fullstep
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reached <= '0;
        end else if (fullstep_i) begin
            reached <= meas_win ? cmp_s2 : 2'b00;
        end else if (meas_win) begin
            reached <= reached | cmp_s2;
        end
    end

    // ************************************
    // Regulator
    // ************************************
    ccr_reg_if rg ();
    logic tgt_zero;
    logic stst_hold;
    logic freeze;
    assign tgt_zero = (actual_current_i == 5'h00);
    assign stst_hold = standstill_reg_disable_i && standstill_i
        && (actual_current_i < run_current_i);
    assign freeze = !vm_now || tgt_zero || stst_hold;
    assign rg.tick = fullstep_i || (standstill_i && period_o);
    assign rg.up = !(&reached);
    assign rg.freeze = freeze;
    assign rg.standstill = standstill_i;
    assign rg.auto_en = auto_amplitude_enable_i;
    assign rg.autograd_en = auto_gradient_enable_i;
    assign rg.gain = regulator_gain_i;
    assign rg.ofs_init = amplitude_offset_i;
    assign rg.grad_init = amplitude_gradient_i;
    ccr_amp_reg u_reg (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .rg         (rg.reg_side)
    );
    assign amplitude_correction_o = rg.corr;
    assign tuned_offset_o = rg.tuned_ofs;
    assign tuned_gradient_o = rg.tuned_grad;

    // ************************************
    // Open-load flags
    // ************************************
    logic ol_active;
    assign ol_active = vm_now && auto_amplitude_enable_i;
    ccr_open_load u_ol_a (
        .core_clk_i  (core_clk_i),
        .rst_n_i     (rst_n_i),
        .active_i    (ol_active),
        .tick_i      (fullstep_i),
        .reached_i   (reached[0]),
        .open_load_o (open_load_coil_a_o)
    );
    ccr_open_load u_ol_b (
        .core_clk_i  (core_clk_i),
        .rst_n_i     (rst_n_i),
        .active_i    (ol_active),
        .tick_i      (fullstep_i),
        .reached_i   (reached[1]),
        .open_load_o (open_load_coil_b_o)
    );

    // ************************************
    // Velocity term: gradient*256/step interval
    // ************************************
    ccr_div_t    div_st;
    logic [20:0] rem;
    logic [15:0] quo;
    logic [4:0]  div_cnt;
    logic [15:0] vel_term;
    logic [20:0] rem_sh;
    logic [7:0]  grad_sel;
    assign grad_sel = rg.tuned_grad;
    assign rem_sh = {rem[19:0], quo[15]};
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_st <= CCR_IDLE;
            rem <= '0;
            quo <= '0;
            div_cnt <= '0;
            vel_term <= '0;
        end else begin
            unique case (div_st)
                CCR_IDLE: begin
                    rem <= '0;
                    quo <= {grad_sel, 8'h00};
                    div_cnt <= '0;
                    div_st <= CCR_DIV;
                end
                CCR_DIV: begin
                    if (rem_sh >= {1'b0, step_interval_i}) begin
                        rem <= rem_sh - {1'b0, step_interval_i};
                        quo <= {quo[14:0], 1'b1};
                    end else begin
                        rem <= rem_sh;
                        quo <= {quo[14:0], 1'b0};
                    end
                    div_cnt <= div_cnt + 5'h01;
                    if (div_cnt == DIV_STEPS - 5'h01) div_st <= CCR_DONE;
                end
                CCR_DONE: begin
                    // Zero interval means standstill: no velocity term
                    vel_term <= (step_interval_i == '0) ? 16'h0000 : quo;
                    div_st <= CCR_IDLE;
                end
                default: div_st <= CCR_IDLE;
            endcase
        end
    end

    // ************************************
    // Total amplitude
    // ************************************
    logic [12:0]        ofs_prod;
    logic signed [17:0] amp_sum;
    logic [9:0]         amp_sat;
    logic [9:0]         cap;
    logic               cap_act;
    assign ofs_prod = rg.tuned_ofs * ({1'b0, actual_current_i} + 6'h01);
    assign amp_sum = $signed({5'h00, ofs_prod[12:5]})
        + $signed({2'b00, vel_term})
        + (auto_amplitude_enable_i ? 18'(rg.corr) : 18'sh00000);
    assign cap = {switch_amplitude_limit_i, 4'hF, 2'b11};
    assign amp_sat = (amp_sum < 0) ? 10'h000 :
                     (amp_sum > $signed({8'h00, TOT_MAX})) ? TOT_MAX :
                     amp_sum[9:0];
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cap_act <= 1'b0;
            total_pwm_amplitude_o <= '0;
        end else begin
            if (reentry) cap_act <= 1'b1;
            else if (fullstep_i || !vm_now) cap_act <= 1'b0;
            total_pwm_amplitude_o <= ((cap_act || reentry) && amp_sat > cap)
                                     ? cap : amp_sat;
        end
    end

    // ************************************
    // Standstill option
    // ************************************
    logic [8:0] stst_cnt;
    logic [8:0] stst_need;
    logic       opt_en;
    assign stst_need = {1'b0, power_down_delay_i} + {5'h00, hold_ramp_delay_i};
    assign opt_en = (hold_current_i == 5'h00) && vm_allowed && standstill_i;
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stst_cnt <= '0;
        end else if (!opt_en) begin
            stst_cnt <= '0;
        end else if (period_o && stst_cnt < stst_need) begin
            stst_cnt <= stst_cnt + 9'h001;
        end
    end
    // 0 normal, 1 standstill_option, 2 low-side short, 3 high-side short
    assign coil_mode_o = (opt_en && stst_cnt >= stst_need)
                         ? standstill_option_i : OPT_NORMAL;

    // ************************************
    // Checks
    // ************************************
    sequence s_reenter;
        !vm_now ##1 vm_now;
    endsequence
    a_vm_thresh: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (step_interval_i < voltage_mode_velocity_threshold_i) |-> !voltage_mode_o)
        else $error("voltage mode below threshold");
    a_force_cc: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        force_current_chopper_i |-> !voltage_mode_o ##1 !pwm_on_o)
        else $error("voltage mode while forced off");
    a_corr_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (!vm_now && $past(!vm_now) && auto_amplitude_enable_i
         && $past(auto_amplitude_enable_i)) |-> $stable(amplitude_correction_o))
        else $error("correction moved in current mode");
    a_reentry_cap: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        s_reenter |=> total_pwm_amplitude_o <= {$past(switch_amplitude_limit_i), 6'h3F})
        else $error("amplitude cap missed on re-entry");
    a_drv_off: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (off_time_setting_i == 4'h0) |-> !driver_enable_o ##1 !pwm_on_o)
        else $error("driver on with zero off time");
    a_ocp_step: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        ocp_threshold_o == ((current_range_i == 2'h3) ? 2'h2 : current_range_i))
        else $error("overcurrent threshold wrong");
    a_blank_len: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (pwm_on_o != $past(pwm_on_o) && blank_time_select_i == 2'h0
         && $stable(blank_time_select_i)) |-> blank_o [*8])
        else $error("blank window too short");
    a_opt_delay: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (coil_mode_o != OPT_NORMAL) |-> hold_current_i == 5'h00 && standstill_i
        && stst_cnt >= stst_need)
        else $error("standstill option too early");
    a_period_n: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (per_cnt == 11'h000 && pwm_rate_select_i == 2'h2
         && $stable(pwm_rate_select_i)) |-> ##256 period_o)
        else $error("chopper half period wrong");
endmodule : ccr_chopper_ctl

// ---- core/ccr_pkg.sv ----
// Purpose: Shared constants for the voltage-mode chopper control
// Assumes: 250 MHz core clock
// Notes:   Chopper counts are core clock cycles
package ccr_pkg;
    // ************************************
    // Widths
    // ************************************
    localparam int THR_W = 20;
    localparam int AMP_W = 10;
    // ************************************
    // Chopper period per rate code (clocks)
    // ************************************
    localparam logic [10:0] PER_N0 = 11'h400;
    localparam logic [10:0] PER_N1 = 11'h2AB;
    localparam logic [10:0] PER_N2 = 11'h200;
    localparam logic [10:0] PER_N3 = 11'h19A;
    // ************************************
    // Blank times per code (clocks)
    // ************************************
    localparam logic [5:0] BLANK_0 = 6'h10;
    localparam logic [5:0] BLANK_1 = 6'h18;
    localparam logic [5:0] BLANK_2 = 6'h24;
    localparam logic [5:0] BLANK_3 = 6'h36;
    // ************************************
    // Limits and reset values
    // ************************************
    localparam logic signed [10:0] CORR_HALF_MAX = 11'sh1FE;
    localparam logic [9:0]  TOT_MAX      = 10'h3FF;
    localparam logic [2:0]  OL_STEPS     = 3'h4;
    localparam logic [4:0]  DIV_STEPS    = 5'h10;
    localparam logic [7:0]  TUNE_RST     = 8'h00;
    localparam logic [1:0]  OCP_MAX      = 2'h2;
    localparam logic [1:0]  OPT_NORMAL   = 2'h0;
    typedef enum logic [1:0] {CCR_IDLE, CCR_DIV, CCR_DONE} ccr_div_t;
endpackage : ccr_pkg

// ---- core/ccr_reg_if.sv ----
// Purpose: Carrier between chopper control and amplitude regulator
// Assumes: Single core clock domain
// Notes:   None
`timescale 1ns/1ns
interface ccr_reg_if;
    logic              tick;
    logic              up;
    logic              freeze;
    logic              standstill;
    logic              auto_en;
    logic              autograd_en;
    logic [3:0]        gain;
    logic [7:0]        ofs_init;
    logic [7:0]        grad_init;
    logic signed [8:0] corr;
    logic [7:0]        tuned_ofs;
    logic [7:0]        tuned_grad;
    modport ctl_side (output tick, up, freeze, standstill, auto_en,
                      output autograd_en, gain, ofs_init, grad_init,
                      input corr, tuned_ofs, tuned_grad);
    modport reg_side (input tick, up, freeze, standstill, auto_en,
                      input autograd_en, gain, ofs_init, grad_init,
                      output corr, tuned_ofs, tuned_grad);
endinterface : ccr_reg_if

// ---- core/ccr_amp_reg.sv ----
// Purpose: Amplitude correction regulator and offset/gradient tuning
// Assumes: tick is a one-cycle pulse per fullstep, or per period_o pulse (two per chopper period) at standstill
// Notes:   Correction kept in half steps
`timescale 1ns/1ns
module ccr_amp_reg
    import ccr_pkg::*;
(
    // Clock and reset
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    // Regulator link
    ccr_reg_if.reg_side rg
);
    logic signed [10:0] corr_half;
    logic signed [11:0] sum_half;
    logic               step;
    assign step     = rg.tick && !rg.freeze && rg.auto_en;
    assign sum_half = rg.up ? corr_half + $signed({8'h00, rg.gain})
                            : corr_half - $signed({8'h00, rg.gain});
    assign rg.corr  = 9'(corr_half >>> 1);

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            corr_half <= '0;
        end else if (!rg.auto_en) begin
            corr_half <= '0;
        end else if (step) begin
            if (sum_half > CORR_HALF_MAX) corr_half <= CORR_HALF_MAX;
            else if (sum_half < -CORR_HALF_MAX) corr_half <= -CORR_HALF_MAX;
            else corr_half <= 11'(sum_half);
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rg.tuned_ofs  <= TUNE_RST;
            rg.tuned_grad <= TUNE_RST;
        end else begin
            if (!rg.auto_en) rg.tuned_ofs <= rg.ofs_init;
            else if (step && rg.standstill) begin
                if (rg.up && rg.tuned_ofs != 8'hFF) rg.tuned_ofs <= rg.tuned_ofs + 8'h01;
                if (!rg.up && rg.tuned_ofs != 8'h00) rg.tuned_ofs <= rg.tuned_ofs - 8'h01;
            end
            if (!rg.auto_en || !rg.autograd_en) rg.tuned_grad <= rg.grad_init;
            else if (step && !rg.standstill) begin
                if (rg.up && rg.tuned_grad != 8'hFF) rg.tuned_grad <= rg.tuned_grad + 8'h01;
                if (!rg.up && rg.tuned_grad != 8'h00) rg.tuned_grad <= rg.tuned_grad - 8'h01;
            end
        end
    end

    a_frozen_corr: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (rg.freeze && rg.auto_en && $past(rg.auto_en)) |=> $stable(corr_half))
        else $error("correction moved while frozen");
endmodule : ccr_amp_reg

// ---- core/ccr_open_load.sv ----
// Purpose: Open-load flag for one coil in voltage mode
// Assumes: tick once per fullstep
// Notes:   Flag stays while target current is never reached
`timescale 1ns/1ns
module ccr_open_load
    import ccr_pkg::*;
(
    // Clock and reset
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    // Evaluation
    input  wire logic active_i,
    input  wire logic tick_i,
    input  wire logic reached_i,
    // Flag
    output logic      open_load_o
);
    logic [2:0] miss;
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            miss <= '0;
        end else if (!active_i || (tick_i && reached_i)) begin
            miss <= '0;
        end else if (tick_i && miss != OL_STEPS) begin
            miss <= miss + 3'h1;
        end
    end
    assign open_load_o = (miss == OL_STEPS);

    a_ol_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (tick_i && reached_i) |=> !open_load_o)
        else $error("open load flag not cleared");
endmodule : ccr_open_load

// ---- sim/ccr_coil_model.sv ----
// Purpose: Coil pair seen through the bridge current comparators
// Assumes: Coil current follows the bridge one cycle late
// Notes:   open_i models an interrupted coil per bit
`timescale 1ns/1ns
module ccr_coil_model (
    // Bridge side
    input  wire logic       core_clk_i,
    input  wire logic       pwm_on_i,
    input  wire logic       en_i,
    input  wire logic [1:0] open_i,
    // Comparators
    output logic            cmp_a_o,
    output logic            cmp_b_o
);
    logic on_q;
    // A broken coil never builds current, so its comparator stays low
    always @(posedge core_clk_i) on_q <= pwm_on_i & en_i;
    assign cmp_a_o = on_q & !open_i[0];
    assign cmp_b_o = on_q & !open_i[1];
endmodule : ccr_coil_model

// ---- sim/tb.sv ----
// Purpose: Self-checking bench for the chopper control
// Assumes: Inputs change on the falling clock edge
// Notes:   Period sweep ends on rate code 2, which stays set
`timescale 1ns/1ns
module tb;
    import ccr_pkg::*;
    typedef struct {
        logic [3:0] ot; logic [1:0] rg; logic fc; logic [19:0] th, st;
        logic de; logic [1:0] oc; logic vm;
    } ccr_row_t;
    logic core_clk_i, rst_n_i, standstill_i, fullstep_i, cmp_a_i, cmp_b_i;
    logic force_current_chopper_i, slow_decay_sense_enable_i, standstill_reg_disable_i;
    logic auto_amplitude_enable_i, auto_gradient_enable_i, driver_enable_o, voltage_mode_o;
    logic pwm_on_o, blank_o, period_o, open_load_coil_a_o, open_load_coil_b_o;
    logic [THR_W-1:0] step_interval_i, voltage_mode_velocity_threshold_i;
    logic [4:0] actual_current_i, hold_current_i, run_current_i;
    logic [3:0] switch_amplitude_limit_i, regulator_gain_i, hold_ramp_delay_i;
    logic [3:0] off_time_setting_i;
    logic [1:0] pwm_rate_select_i, standstill_option_i, current_range_i, blank_time_select_i;
    logic [1:0] coil_mode_o, ocp_threshold_o, open_i;
    logic [7:0] amplitude_offset_i, amplitude_gradient_i, power_down_delay_i;
    logic [7:0] tuned_offset_o, tuned_gradient_o;
    logic [AMP_W-1:0] total_pwm_amplitude_o;
    logic signed [8:0] amplitude_correction_o;
    int failures = 0, n_tests = 0, cyc = 0, k = 0;
    int per [4] = '{1024, 683, 512, 410};
    ccr_row_t rows [5] = '{
        '{4'h0, 2'h0, 1'b0, 20'h0, 20'h5, 1'b0, 2'h0, 1'b0},
        '{4'h1, 2'h1, 1'b0, 20'h64, 20'h63, 1'b1, 2'h1, 1'b0},
        '{4'hF, 2'h2, 1'b0, 20'h64, 20'h64, 1'b1, 2'h2, 1'b1},
        '{4'h3, 2'h3, 1'b1, 20'h0, 20'h5, 1'b1, 2'h2, 1'b0},
        '{4'h8, 2'h3, 1'b0, 20'hFFFFF, 20'hFFFFE, 1'b1, 2'h2, 1'b0}};
    ccr_chopper_ctl u_ccr_chopper_ctl (.*);
    ccr_coil_model u_ccr_coil_model (.core_clk_i(core_clk_i), .pwm_on_i(pwm_on_o),
        .en_i(driver_enable_o), .open_i(open_i), .cmp_a_o(cmp_a_i), .cmp_b_o(cmp_b_i));
    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            failures++;
            give_verdict();
        end
    end
    task automatic chk(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1) begin
            failures++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask : chk
    // Counts falling edges up to the n-th chopper period pulse
    task automatic wp(input int n);
        repeat (n) begin
            do begin
                @(negedge core_clk_i);
                k++;
            end while (period_o !== 1'b1);
        end
    endtask : wp
    task automatic fs();
        fullstep_i = 1'b1;
        @(negedge core_clk_i);
        fullstep_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
    endtask : fs
    task automatic give_verdict();
        if (failures == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    // ************************************
    // Main sequence
    // ************************************
    initial begin
        {fullstep_i, standstill_i, force_current_chopper_i, slow_decay_sense_enable_i,
         standstill_reg_disable_i, auto_amplitude_enable_i, auto_gradient_enable_i,
         hold_ramp_delay_i, standstill_option_i, current_range_i, blank_time_select_i,
         step_interval_i, voltage_mode_velocity_threshold_i, open_i, rst_n_i} = '0;
        {actual_current_i, hold_current_i, run_current_i} = {5'h10, 5'h08, 5'h1F};
        {switch_amplitude_limit_i, regulator_gain_i, off_time_setting_i} = 12'hC21;
        {amplitude_offset_i, amplitude_gradient_i, power_down_delay_i} = 24'h641002;
        pwm_rate_select_i = 2'h3;
        repeat (5) @(negedge core_clk_i);
        chk(total_pwm_amplitude_o === 10'h000, "amplitude in reset");
        rst_n_i = 1'b1;
        repeat (3) @(negedge core_clk_i);
        chk(tuned_offset_o === 8'h64, "tuned offset start");
        chk(tuned_gradient_o === 8'h10, "programmed gradient");
        foreach (rows[i]) begin
            {off_time_setting_i, current_range_i, force_current_chopper_i} =
                {rows[i].ot, rows[i].rg, rows[i].fc};
            voltage_mode_velocity_threshold_i = rows[i].th;
            step_interval_i = rows[i].st;
            @(negedge core_clk_i);
            chk({driver_enable_o, ocp_threshold_o, voltage_mode_o} ===
                {rows[i].de, rows[i].oc, rows[i].vm}, "mode row");
        end
        {voltage_mode_velocity_threshold_i, step_interval_i} = {20'h0, 20'h5};
        for (int r = 0; r < 4; r++) begin
            // Code 2 last: leaving it would cut a half-period check short
            pwm_rate_select_i = 2'(r + 3);
            blank_time_select_i = 2'(r);
            wp(2);
            k = 0;
            wp(2);
            chk(k == per[pwm_rate_select_i], "chopper period");
        end
        {auto_amplitude_enable_i, standstill_reg_disable_i, standstill_i} = 3'b111;
        open_i = 2'b01;
        wp(256);
        // Frozen fullstep drops comparator history from the period sweep
        fs();
        chk(amplitude_correction_o === 9'sd0, "standstill freeze");
        {standstill_reg_disable_i, standstill_i} = 2'b00;
        repeat (4) begin
            wp(2);
            fs();
        end
        chk({open_load_coil_a_o, open_load_coil_b_o} === 2'b10, "open load set");
        chk(amplitude_correction_o === 9'sd4, "correction up");
        open_i = 2'b00;
        wp(2);
        fs();
        chk({open_load_coil_a_o, open_load_coil_b_o} === 2'b00, "open load clear");
        chk(amplitude_correction_o === 9'sd3, "correction down");
        {actual_current_i, run_current_i, open_i} = {5'h00, 5'h0F, 2'b11};
        wp(2);
        fs();
        chk(amplitude_correction_o === 9'sd3, "zero current");
        {actual_current_i, voltage_mode_velocity_threshold_i} = {5'h10, 20'h64};
        fs();
        chk(amplitude_correction_o === 9'sd3, "current mode");
        voltage_mode_velocity_threshold_i = 20'h0;
        wp(2);
        fs();
        chk(amplitude_correction_o === 9'sd4, "resume");
        chk(total_pwm_amplitude_o === 10'h36C, "amplitude sum");
        {hold_current_i, hold_ramp_delay_i, standstill_option_i} = {5'h00, 4'h1, 2'h3};
        standstill_i = 1'b1;
        @(negedge core_clk_i);
        chk(coil_mode_o === 2'h0, "option early");
        wp(4);
        for (int o = 0; o < 4; o++) begin
            standstill_option_i = 2'(o);
            @(negedge core_clk_i);
            chk(coil_mode_o === 2'(o), "standstill option");
        end
        give_verdict();
    end
endmodule : tb
